/* design/pcitc_top.sv */
// pci host bridge target control: read retry engine, bridge and interrupt registers
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pcitc_defines.svh"

module pcitc_top
#(
  parameter int unsigned DISCARD_CLKS = `PCITC_DISCARD_CLKS
)
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire pcitc_pkg::pcitc_tgt_req_t tgt_req,
  output pcitc_pkg::pcitc_tgt_rsp_t      tgt_rsp,
  output pcitc_pkg::pcitc_mem_req_t      mem_req,
  input  wire pcitc_pkg::pcitc_mem_rsp_t mem_rsp,
  input  wire logic                      addr_parity_err,
  input  wire logic                      data_parity_err,
  output logic                           pci_bus_reset,
  output logic                           cpu_write_post_enable,
  output logic                           irq,
  output logic                           nmi
);
  import pcitc_pkg::*;

  // ==========================================================================
  // register decode
  function automatic logic [1:0] pcitc_decode(input logic [11:0] a);
    logic [1:0] sel;
    sel = `PCITC_SEL_NONE;
    if (a[1:0] == 2'h0)
    begin
      case (a[11:2])
        `PCITC_IDX_BRIDGE_CONTROL:     sel = `PCITC_SEL_BCTL;
        `PCITC_IDX_TARGET_IRQ_CONTROL: sel = `PCITC_SEL_TIC;
        `PCITC_IDX_TARGET_IRQ_STATUS:  sel = `PCITC_SEL_STA;
        default:                       sel = `PCITC_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  pcitc_state_t s;
  pcitc_state_t next_s;
  logic [1:0]   mode;
  logic [1:0]   dec;
  logic         bus_wr;
  logic         match;
  logic [2:0]   ev;
  logic [2:0]   w1c;
  logic [2:0]   next_en;
  logic [2:0]   next_sel;
  logic         wait_start;
  logic         wait_clear;
  logic         wait_expired;
  logic         disc_start;
  logic         disc_clear;
  logic         disc_expired;

  assign mode = s.bctl[`PCITC_BC_MODE_HI:`PCITC_BC_MODE_LO];

  // ==========================================================================
  // timers: first-data wait and unclaimed-completion discard
  pcitc_timer
  #(
    .W     (`PCITC_WAIT_W),
    .LIMIT (`PCITC_WAIT_CLKS)
  )
  u_wait_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (wait_start),
    .clear   (wait_clear),
    .expired (wait_expired)
  );

  pcitc_timer
  #(
    .W     (`PCITC_DISCARD_W),
    .LIMIT (DISCARD_CLKS)
  )
  u_discard_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (disc_start),
    .clear   (disc_clear),
    .expired (disc_expired)
  );

  // ==========================================================================
  // next state
  always_comb
  begin
    next_s = s;
    next_s.rsp.data_valid = 1'b0;
    next_s.rsp.retry = 1'b0;
    wait_start = 1'b0;
    wait_clear = 1'b0;
    disc_start = 1'b0;
    disc_clear = 1'b0;
    ev = 3'h0;
    w1c = 3'h0;
    dec = pcitc_decode(paddr);
    bus_wr = psel && penable && pwrite && s.pready;
    match = (tgt_req.addr == s.dt_addr);

    // apb: data and pready registered in setup, access lasts one cycle
    if (psel && !penable)
    begin
      next_s.pready = 1'b1;
      next_s.pslverr = (dec == `PCITC_SEL_NONE);
      case (dec)
        `PCITC_SEL_BCTL: next_s.prdata = {16'h0000, s.bctl};
        `PCITC_SEL_TIC:  next_s.prdata = {16'h0000, s.tic};
        `PCITC_SEL_STA:  next_s.prdata = {29'h0000000, s.sta};
        default:         next_s.prdata = 32'h00000000;
      endcase
    end
    else if (psel && penable && s.pready)
    begin
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
    end

    // reserved bits are dropped on write so they always read zero
    if (bus_wr)
    begin
      case (dec)
        `PCITC_SEL_BCTL: next_s.bctl = pwdata[15:0] & `PCITC_BC_WMASK;
        `PCITC_SEL_TIC:  next_s.tic = pwdata[15:0] & `PCITC_TIC_WMASK;
        `PCITC_SEL_STA:  w1c = pwdata[2:0];
        default:         w1c = 3'h0;
      endcase
    end

    // read engine
    case (s.fsm)
      PCITC_IDLE:
      begin
        if (tgt_req.req)
        begin
          next_s.mem.req = 1'b1;
          next_s.mem.addr = tgt_req.addr;
          next_s.dt_addr = tgt_req.addr;
          next_s.fsm = PCITC_FETCH;
          if (mode == `PCITC_MODE_DELAYED)
          begin
            next_s.rsp.retry = 1'b1;
          end
          else
          begin
            // reserved codes behave as the wait mode
            next_s.held = 1'b1;
            wait_start = 1'b1;
          end
        end
      end
      PCITC_FETCH:
      begin
        if (mem_rsp.ack)
        begin
          next_s.mem.req = 1'b0;
          wait_clear = 1'b1;
          if (s.held)
          begin
            next_s.held = 1'b0;
            next_s.rsp.data_valid = 1'b1;
            next_s.rsp.rdata = mem_rsp.rdata;
            next_s.fsm = PCITC_IDLE;
          end
          else
          begin
            // completed in the background, kept for the reissued read
            next_s.dt_data = mem_rsp.rdata;
            next_s.fsm = PCITC_DONE;
            disc_start = 1'b1;
          end
        end
        else if (s.held && wait_expired)
        begin
          next_s.held = 1'b0;
          next_s.rsp.retry = 1'b1;
        end
        // single completion slot: a read arriving during a background (not held) fetch is retried
        if (tgt_req.req && !s.held)
        begin
          next_s.rsp.retry = 1'b1;
        end
      end
      PCITC_DONE:
      begin
        if (tgt_req.req && match)
        begin
          next_s.rsp.data_valid = 1'b1;
          next_s.rsp.rdata = s.dt_data;
          next_s.fsm = PCITC_IDLE;
          disc_clear = 1'b1;
        end
        else
        begin
          if (tgt_req.req)
          begin
            next_s.rsp.retry = 1'b1;
          end
          if (disc_expired)
          begin
            ev[`PCITC_EV_DLY_TO] = 1'b1;
            next_s.fsm = PCITC_IDLE;
          end
        end
      end
      default:
      begin
        next_s.fsm = PCITC_IDLE;
      end
    endcase

    ev[`PCITC_EV_ADDR_PAR] = addr_parity_err;
    ev[`PCITC_EV_DATA_PAR] = data_parity_err;

    // ==========================================================================
    // interrupts: a new event wins over a clear in the same cycle
    next_s.sta = (s.sta & ~w1c) | ev;
    next_en = next_s.tic[`PCITC_TIC_EN_HI:`PCITC_TIC_EN_LO];
    next_sel = next_s.tic[`PCITC_TIC_SEL_HI:`PCITC_TIC_SEL_LO];
    next_s.irq = |(next_s.sta & next_en & ~next_sel);
    next_s.nmi = |(next_s.sta & next_en & next_sel);
  end

  // pci bus reset is not wired here on purpose: only presetn clears the registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.bctl <= `PCITC_BC_RESET;
      s.tic <= `PCITC_TIC_RESET;
      s.sta <= `PCITC_STA_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign tgt_rsp = s.rsp;
  assign mem_req = s.mem;
  assign pci_bus_reset = s.bctl[`PCITC_BC_PCI_RST];
  assign cpu_write_post_enable = s.bctl[`PCITC_BC_WPOST];
  assign irq = s.irq;
  assign nmi = s.nmi;

  // ==========================================================================
  // checks
  logic [5:0] hold_cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_cnt <= 6'h00;
    end
    else
    begin
      hold_cnt <= s.held ? hold_cnt + 6'h01 : 6'h00;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_hold_bound;
    s.held |-> hold_cnt <= 6'h20;
  endproperty
  a_hold_bound: assert property (p_hold_bound) else $error("master held too long");

  property p_hold_retry;
    s.held && wait_expired && !mem_rsp.ack |=> tgt_rsp.retry && !s.held;
  endproperty
  a_hold_retry: assert property (p_hold_retry) else $error("no retry after wait");

  property p_delayed_retry;
    tgt_req.req && s.fsm == PCITC_IDLE && mode == `PCITC_MODE_DELAYED
      |=> tgt_rsp.retry && mem_req.req && !tgt_rsp.data_valid;
  endproperty
  a_delayed_retry: assert property (p_delayed_retry) else $error("delayed read not retried");

  property p_serve_match;
    tgt_req.req && s.fsm == PCITC_DONE && tgt_req.addr == s.dt_addr
      |=> tgt_rsp.data_valid && !tgt_rsp.retry && tgt_rsp.rdata == $past(s.dt_data);
  endproperty
  a_serve_match: assert property (p_serve_match) else $error("completed read not served");

  property p_wpost;
    bus_wr && dec == `PCITC_SEL_BCTL |=> cpu_write_post_enable == $past(pwdata[3]);
  endproperty
  a_wpost: assert property (p_wpost) else $error("write post enable wrong");

  property p_pci_rst;
    bus_wr && dec == `PCITC_SEL_BCTL |=> pci_bus_reset == $past(pwdata[15]);
  endproperty
  a_pci_rst: assert property (p_pci_rst) else $error("pci bus reset wrong");

  property p_bctl_keep;
    !(bus_wr && dec == `PCITC_SEL_BCTL) |=> $stable(s.bctl);
  endproperty
  a_bctl_keep: assert property (p_bctl_keep) else $error("bridge control changed");

  property p_sticky;
    addr_parity_err |=> s.sta[`PCITC_EV_ADDR_PAR];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status not set");

  property p_irq_route;
    irq == |(s.sta & s.tic[2:0] & ~s.tic[10:8]);
  endproperty
  a_irq_route: assert property (p_irq_route) else $error("maskable irq wrong");

  property p_nmi_dt;
    s.sta[2] && s.tic[2] && s.tic[10] |-> nmi;
  endproperty
  a_nmi_dt: assert property (p_nmi_dt) else $error("time-out nmi missing");

  property p_disabled;
    s.tic[2:0] == 3'h0 |-> !irq && !nmi;
  endproperty
  a_disabled: assert property (p_disabled) else $error("interrupt while disabled");

endmodule

`default_nettype wire

/* design/pcitc_defines.svh */
// register map, field positions, reset values and timing counts of the target control block
`ifndef PCITC_DEFINES_SVH
`define PCITC_DEFINES_SVH

// ==========================================================================
// register indices (byte address = index * 4)
`define PCITC_IDX_BRIDGE_CONTROL     10'h060
`define PCITC_IDX_TARGET_IRQ_CONTROL 10'h062
`define PCITC_IDX_TARGET_IRQ_STATUS  10'h064

// decoder select codes
`define PCITC_SEL_NONE 2'h0
`define PCITC_SEL_BCTL 2'h1
`define PCITC_SEL_TIC  2'h2
`define PCITC_SEL_STA  2'h3

// ==========================================================================
// bridge_control fields
`define PCITC_BC_PCI_RST   15
`define PCITC_BC_MODE_HI   9
`define PCITC_BC_MODE_LO   8
`define PCITC_BC_WPOST     3
`define PCITC_BC_WMASK     16'h8308
`define PCITC_BC_RESET     16'h0000

// auto_delayed_read_mode codes
`define PCITC_MODE_WAIT    2'h0
`define PCITC_MODE_DELAYED 2'h1

// ==========================================================================
// target_irq_control fields; event bit n has its select at n + 8
`define PCITC_TIC_SEL_HI   10
`define PCITC_TIC_SEL_LO   8
`define PCITC_TIC_EN_HI    2
`define PCITC_TIC_EN_LO    0
`define PCITC_TIC_WMASK    16'h0707
`define PCITC_TIC_RESET    16'h0000

// status event bits
`define PCITC_EV_DATA_PAR  0
`define PCITC_EV_ADDR_PAR  1
`define PCITC_EV_DLY_TO    2
`define PCITC_STA_RESET    3'h0

// ==========================================================================
// timing, in pci clocks
`define PCITC_WAIT_CLKS    32
`define PCITC_WAIT_W       6
`define PCITC_DISCARD_CLKS 32768
`define PCITC_DISCARD_W    16

`endif

/* design/pcitc_pkg.sv */
// types shared by the target control block
package pcitc_pkg;

  typedef enum logic [1:0]
  {
    PCITC_IDLE  = 2'b00,
    PCITC_FETCH = 2'b01,
    PCITC_DONE  = 2'b10
  } pcitc_fsm_t;

  typedef struct packed
  {
    logic        req;
    logic [31:0] addr;
  } pcitc_tgt_req_t;

  typedef struct packed
  {
    logic        data_valid;
    logic        retry;
    logic [31:0] rdata;
  } pcitc_tgt_rsp_t;

  typedef struct packed
  {
    logic        req;
    logic [31:0] addr;
  } pcitc_mem_req_t;

  typedef struct packed
  {
    logic        ack;
    logic [31:0] rdata;
  } pcitc_mem_rsp_t;

  typedef struct packed
  {
    pcitc_fsm_t     fsm;
    logic           held;
    logic [31:0]    dt_addr;
    logic [31:0]    dt_data;
    logic [15:0]    bctl;
    logic [15:0]    tic;
    logic [2:0]     sta;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    pcitc_tgt_rsp_t rsp;
    pcitc_mem_req_t mem;
    logic           irq;
    logic           nmi;
  } pcitc_state_t;

endpackage

/* design/pcitc_timer.sv */
// one-shot cycle timer: expired pulses LIMIT clocks after start
`timescale 1ns/1ps
`default_nettype none

module pcitc_timer
#(
  parameter int unsigned W     = 6,
  parameter int unsigned LIMIT = 32
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  input  wire logic clear,
  output logic      expired
);

  typedef struct packed
  {
    logic         run;
    logic [W-1:0] cnt;
    logic         expired;
  } pcitc_timer_st_t;

  pcitc_timer_st_t s;
  pcitc_timer_st_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.expired = 1'b0;
    if (clear)
    begin
      next_s.run = 1'b0;
    end
    else if (start)
    begin
      next_s.run = 1'b1;
      next_s.cnt = '0;
    end
    else if (s.run)
    begin
      if (s.cnt == W'(LIMIT - 1))
      begin
        next_s.run     = 1'b0;
        next_s.expired = 1'b1;
      end
      else
      begin
        next_s.cnt = s.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign expired = s.expired;

endmodule

`default_nettype wire

/* dv/pcitc_mem_model.sv */
// sdram model answering the fetch port of the target control block
`timescale 1ns/1ps
`default_nettype none

module pcitc_mem_model
#(
  parameter logic [31:0] KEY = 32'h5a5a_0000
)
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [7:0]                delay,
  input  wire pcitc_pkg::pcitc_mem_req_t mem_req,
  output pcitc_pkg::pcitc_mem_rsp_t      mem_rsp
);
  import pcitc_pkg::*;
  logic [7:0] wait_cnt;

  // ==========================================================================
  // responder
  // one ack per held request; data toggles between acks so stale data never looks valid
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_cnt <= 8'h00;
      mem_rsp  <= '{ack: 1'b0, rdata: 32'hffff_ffff};
    end
    else
    begin
      mem_rsp.ack   <= 1'b0;
      mem_rsp.rdata <= ~mem_rsp.rdata;
      if (mem_req.req && !mem_rsp.ack)
      begin
        if (wait_cnt >= delay)
        begin
          wait_cnt      <= 8'h00;
          mem_rsp.ack   <= 1'b1;
          mem_rsp.rdata <= mem_req.addr ^ KEY;
        end
        else
          wait_cnt <= wait_cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/pci_bridge_target_control_test.sv */
// self-checking bench of the target control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("MISMATCH %s expected %h seen %h", nm, e, g); \
    end \
  end

module pci_bridge_target_control_test;
  import pcitc_pkg::*;
  localparam int          DISC = 64;
  localparam logic [31:0] KEY  = 32'h5a5a_0000;
  typedef struct {logic [11:0] a; logic [31:0] wd; logic [31:0] rd; logic err;} pcitc_row_t;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd, d;
  logic             addr_parity_err, data_parity_err, err;
  logic             pci_bus_reset, cpu_write_post_enable, irq, nmi;
  logic [7:0]       delay;
  logic [1:0]       vr;
  pcitc_tgt_req_t   tgt_req;
  pcitc_tgt_rsp_t   tgt_rsp;
  pcitc_mem_req_t   mem_req;
  pcitc_mem_rsp_t   mem_rsp;
  int               n_mismatch, checks_done, cyc, n;
  pcitc_row_t       rows [7];

  pcitc_top #(.DISCARD_CLKS(DISC)) i_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tgt_req(tgt_req), .tgt_rsp(tgt_rsp), .mem_req(mem_req), .mem_rsp(mem_rsp),
    .addr_parity_err(addr_parity_err), .data_parity_err(data_parity_err),
    .pci_bus_reset(pci_bus_reset), .cpu_write_post_enable(cpu_write_post_enable),
    .irq(irq), .nmi(nmi)
  );
  pcitc_mem_model #(.KEY(KEY)) i_mem
  (
    .pclk(pclk), .presetn(presetn), .delay(delay), .mem_req(mem_req), .mem_rsp(mem_rsp)
  );

  // ==========================================================================
  // clock, timeout, verdict
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================================
  // bus and master tasks
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no local limit: only the bench timeout ends a stuck access
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one read attempt; waits for data or retry before the next attempt
  task automatic tgt_rd(input logic [31:0] a);
    @(posedge pclk);
    tgt_req <= '{req: 1'b1, addr: a};
    @(posedge pclk);
    tgt_req <= '{req: 1'b0, addr: ~a};
    n = 0;
    #1;
    while (tgt_rsp.data_valid !== 1'b1 && tgt_rsp.retry !== 1'b1 && n < 100)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    vr = {tgt_rsp.data_valid, tgt_rsp.retry};
    d = tgt_rsp.rdata;
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    // defined bits read back as written; unmapped and misaligned addresses return pslverr
    rows = '{'{12'h180, 32'h0000_8108, 32'h0000_8108, 1'b0},
             '{12'h180, 32'h0000_0008, 32'h0000_0008, 1'b0},
             '{12'h180, 32'h0000_0000, 32'h0000_0000, 1'b0},
             '{12'h188, 32'h0000_0707, 32'h0000_0707, 1'b0},
             '{12'h188, 32'h0000_0000, 32'h0000_0000, 1'b0},
             '{12'h000, 32'h0000_0001, 32'h0000_0000, 1'b1},
             '{12'h18a, 32'h0000_ffff, 32'h0000_0000, 1'b1}};
    {presetn, psel, penable, pwrite, addr_parity_err, data_parity_err} = '0;
    paddr = '0;
    pwdata = '0;
    delay = 8'h03;
    tgt_req = '{req: 1'b0, addr: 32'h0};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, 12'(12'h180 + 8 * i), 32'h0);
      `CHK("reset_value", 32'h0, rd)
    end
    `CHK("reset_outs", 4'h0, {pci_bus_reset, cpu_write_post_enable, irq, nmi})
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].wd);
      apb(1'b0, rows[i].a, 32'h0);
      `CHK("readback", rows[i].rd, rd)
      `CHK("slverr", rows[i].err, err)
      if (rows[i].a == 12'h180)
        `CHK("bctl_outs", {rd[15], rd[3]}, {pci_bus_reset, cpu_write_post_enable})
      `CHK("post_en", rows[i].rd[3] & (rows[i].a == 12'h180), cpu_write_post_enable)
    end
    for (int e = 0; e < 2; e++)
      for (int k = 0; k < 4; k++)
      begin
        apb(1'b1, 12'h188, 32'((k / 2) << (e + 8) | (k % 2) << e));
        @(posedge pclk);
        data_parity_err <= (e == 0);
        addr_parity_err <= (e == 1);
        @(posedge pclk);
        {data_parity_err, addr_parity_err} <= 2'b00;
        repeat (2) @(posedge pclk);
        #1;
        `CHK("irq", k == 1, irq)
        `CHK("nmi", k == 3, nmi)
        apb(1'b0, 12'h190, 32'h0);
        `CHK("status", 32'(1 << e), rd)
        apb(1'b1, 12'h190, 32'h0000_0007);
        apb(1'b0, 12'h190, 32'h0);
        `CHK("cleared", 34'h0, {irq, nmi, rd})
      end
    apb(1'b1, 12'h180, 32'h0000_0000);
    tgt_rd(32'h0000_1000);
    `CHK("wait_ok", 2'b10, vr)
    `CHK("wait_data", 32'h0000_1000 ^ KEY, d)
    `CHK("wait_short", 1'b1, n < 32)
    delay = 8'd60;
    tgt_rd(32'h0000_2000);
    `CHK("wait_retry", 2'b01, vr)
    `CHK("wait_32", 1'b1, n >= 31 && n <= 33)
    repeat (40) @(posedge pclk);
    tgt_rd(32'h0000_2000);
    `CHK("reissue", {2'b10, 32'h0000_2000 ^ KEY}, {vr, d})
    delay = 8'd5;
    apb(1'b1, 12'h180, 32'h0000_0100);
    tgt_rd(32'h0000_3000);
    `CHK("dly_retry", 2'b01, vr)
    tgt_rd(32'h0000_4000);
    `CHK("busy_retry", 2'b01, vr)
    repeat (20) @(posedge pclk);
    tgt_rd(32'h0000_3000);
    `CHK("dly_data", {2'b10, 32'h0000_3000 ^ KEY}, {vr, d})
    apb(1'b1, 12'h188, 32'h0000_0400);
    tgt_rd(32'h0000_3000);
    `CHK("used_retry", 2'b01, vr)
    repeat (DISC + 40) @(posedge pclk);
    apb(1'b0, 12'h190, 32'h0);
    `CHK("to_status", 34'h4, {irq, nmi, rd})
    apb(1'b1, 12'h188, 32'h0000_0404);
    repeat (2) @(posedge pclk);
    `CHK("to_nmi", 2'b01, {irq, nmi})
    apb(1'b1, 12'h188, 32'h0000_0004);
    repeat (2) @(posedge pclk);
    `CHK("to_irq", 2'b10, {irq, nmi})
    apb(1'b1, 12'h180, 32'h0000_8008);
    apb(1'b0, 12'h180, 32'h0);
    `CHK("bus_rst_keep", {2'b11, 32'h0000_8008}, {pci_bus_reset, cpu_write_post_enable, rd})
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h180, 32'h0);
    `CHK("sys_reset", 36'h0, {pci_bus_reset, cpu_write_post_enable, irq, nmi, rd})
    report_and_stop();
  end
endmodule
`default_nettype wire
